// ==== inc/mdrp_pkg.sv ====
// constants and types for the motor driver reset/protect block
//Contract
//RULE_01: A low power-save input means standby mode and a high level means normal operation.
//RULE_02: Entering standby or undervoltage lockout clears every internal register to zero.
//RULE_03: All output drivers are forced off during standby, undervoltage lockout or thermal shutdown.
//RULE_04: Thermal shutdown and the per-channel soft-reset bit leave the internal registers unchanged.
//RULE_05: With its soft-reset bit set, a channel's driver is on and follows its channel enable pin.
//RULE_06: The host waits more than 100ns after power-save goes high before any serial activity.
//RULE_07: While standby or lockout lasts, registers stay zero and serial writes are ignored.
package mdrp_pkg;
	localparam int          CH_NUM        = 5;
	localparam int          REG_NUM       = 16;
	localparam int          ADDR_W        = 4;
	localparam int          DATA_W        = 8;
	localparam logic [3:0]  SOFT_RST_ADDR = 4'h9;
	localparam logic [7:0]  REG_RST_VAL   = 8'h00;
	localparam int          WAKE_NS       = 100;
	localparam int          CLK_PERIOD_NS = 8;
	// least time, rounded up to whole cycles
	localparam int          WAKE_CYC      = (WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int          WAKE_CNT_W    = 4;
	localparam logic [3:0]  WAKE_CNT_MAX  = 4'(WAKE_CYC);

	typedef enum logic [1:0] {
		MDRP_ST_STANDBY,
		MDRP_ST_WAKE,
		MDRP_ST_RUN
	} mdrp_state_e;
endpackage

// ==== inc/mdrp_reg_if.sv ====
// carrier between the protect control and the register file
`timescale 1ns/100ps
interface mdrp_reg_if;
	import mdrp_pkg::*;
	logic                wr_en;
	logic [ADDR_W-1:0]   wr_addr;
	logic [DATA_W-1:0]   wr_data;
	logic                clr;
	logic [ADDR_W-1:0]   rd_addr;
	logic [DATA_W-1:0]   rd_data;
	logic [CH_NUM-1:0]   soft_rst;

	modport ctrl (
		output wr_en, wr_addr, wr_data, clr, rd_addr,
		input  rd_data, soft_rst
	);
	modport rf (
		input  wr_en, wr_addr, wr_data, clr, rd_addr,
		output rd_data, soft_rst
	);
endinterface

// ==== logic/mdrp_regfile.sv ====
// internal register file with level clear
`timescale 1ns/100ps
module mdrp_regfile
	import mdrp_pkg::*;
(
	// clock and reset
	input  wire logic clk_i,
	input  wire logic srst_i,
	// register access
	mdrp_reg_if.rf    rif
);
	logic [DATA_W-1:0] regs_r [REG_NUM];

	always_ff @(posedge clk_i) begin
		if (srst_i || rif.clr) begin
			for (int i = 0; i < REG_NUM; i++) begin
				regs_r[i] <= REG_RST_VAL; // RULE_02 RULE_07
			end
		end else if (rif.wr_en) begin
			regs_r[rif.wr_addr] <= rif.wr_data;
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			rif.rd_data <= REG_RST_VAL;
		end else begin
			rif.rd_data <= regs_r[rif.rd_addr];
		end
	end

	assign rif.soft_rst = regs_r[SOFT_RST_ADDR][CH_NUM-1:0];

	a_clear_holds_zero: assert property (@(posedge clk_i) disable iff (srst_i) // RULE_07
		rif.clr |=> (regs_r[rif.wr_addr] == REG_RST_VAL))
		else $error("register not zero after clear");
endmodule

// ==== logic/mdrp_top.sv ====
// reset and protection control for the motor driver channels
`timescale 1ns/100ps
module mdrp_top
	import mdrp_pkg::*;
(
	// clock and reset
	input  wire logic              clk_i,
	input  wire logic              srst_i,
	// protection pins
	input  wire logic              power_save_input_i,
	input  wire logic              undervoltage_lockout_i,
	input  wire logic              thermal_shutdown_i,
	input  wire logic [CH_NUM-1:0] channel_enable_pin_i,
	// serial register writes
	input  wire logic              ser_wr_valid_i,
	input  wire logic [ADDR_W-1:0] ser_wr_addr_i,
	input  wire logic [DATA_W-1:0] ser_wr_data_i,
	output logic                   ser_wr_ready_o,
	// register readback
	input  wire logic [ADDR_W-1:0] rd_addr_i,
	output logic [DATA_W-1:0]      rd_data_o,
	// driver control
	input  wire logic [CH_NUM-1:0] drv_req_i,
	output logic [CH_NUM-1:0]      drv_on_o,
	output logic                   standby_o,
	output logic                   regs_clear_o
);
	localparam int SYNC_W = CH_NUM + 3;

	logic [SYNC_W-1:0] sync1_r;
	logic [SYNC_W-1:0] sync2_r;
	logic              ps_s;
	logic              lockout_s;
	logic              therm_s;
	logic [CH_NUM-1:0] en_s;
	logic              clr_lvl;
	logic              drv_kill;
	mdrp_state_e       state_r;
	mdrp_state_e       state_nxt;
	logic [WAKE_CNT_W-1:0] wake_cnt_r;
	logic [CH_NUM-1:0] drv_on_nxt;
	logic [4:0]        calm_cnt_r;

	mdrp_reg_if rif ();

	// two-stage pin synchronisers
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			sync1_r <= '0;
			sync2_r <= '0;
		end else begin
			sync1_r <= {power_save_input_i, undervoltage_lockout_i, thermal_shutdown_i, channel_enable_pin_i};
			sync2_r <= sync1_r;
		end
	end

	assign ps_s      = sync2_r[SYNC_W-1];
	assign lockout_s = sync2_r[SYNC_W-2];
	assign therm_s   = sync2_r[SYNC_W-3];
	assign en_s      = sync2_r[CH_NUM-1:0];

	// standby is a low level on power-save
	assign clr_lvl  = ~ps_s | lockout_s; // RULE_01 RULE_02
	assign drv_kill = clr_lvl | therm_s; // RULE_03

	// wake sequence after power-save release
	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			MDRP_ST_STANDBY: begin
				if (!clr_lvl) begin
					state_nxt = MDRP_ST_WAKE;
				end
			end
			MDRP_ST_WAKE: begin
				if (clr_lvl) begin
					state_nxt = MDRP_ST_STANDBY;
				end else if (wake_cnt_r == WAKE_CNT_MAX) begin
					state_nxt = MDRP_ST_RUN;
				end
			end
			MDRP_ST_RUN: begin
				if (clr_lvl) begin
					state_nxt = MDRP_ST_STANDBY;
				end
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			state_r <= MDRP_ST_STANDBY;
		end else begin
			state_r <= state_nxt;
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i || state_r != MDRP_ST_WAKE) begin
			wake_cnt_r <= '0;
		end else begin
			wake_cnt_r <= wake_cnt_r + 4'h1; // RULE_06
		end
	end

	// writes only once running; thermal shutdown does not block them
	assign ser_wr_ready_o = (state_r == MDRP_ST_RUN) && !clr_lvl; // RULE_06 RULE_07 RULE_04

	assign rif.wr_en   = ser_wr_valid_i && ser_wr_ready_o; // RULE_07
	assign rif.wr_addr = ser_wr_addr_i;
	assign rif.wr_data = ser_wr_data_i;
	assign rif.clr     = clr_lvl; // RULE_02 RULE_07
	assign rif.rd_addr = rd_addr_i;
	assign rd_data_o   = rif.rd_data;

	mdrp_regfile u_regfile (
		.clk_i  (clk_i),
		.srst_i (srst_i),
		.rif    (rif.rf)
	);

	// soft-reset hands the channel to its enable pin
	always_comb begin
		for (int c = 0; c < CH_NUM; c++) begin
			drv_on_nxt[c] = rif.soft_rst[c] ? en_s[c] : drv_req_i[c]; // RULE_05
		end
		if (drv_kill) begin
			drv_on_nxt = '0; // RULE_03
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			drv_on_o     <= '0;
			standby_o    <= 1'b1;
			regs_clear_o <= 1'b1;
		end else begin
			drv_on_o     <= drv_on_nxt;
			standby_o    <= ~ps_s; // RULE_01
			regs_clear_o <= clr_lvl;
		end
	end

	// cycles since the clear level dropped, saturating
	always_ff @(posedge clk_i) begin
		if (srst_i || clr_lvl) begin
			calm_cnt_r <= 5'h00;
		end else if (calm_cnt_r != 5'h1F) begin
			calm_cnt_r <= calm_cnt_r + 5'h01;
		end
	end

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (srst_i);

	sequence s_wake_start;
		!clr_lvl && $past(clr_lvl);
	endsequence

	sequence s_held_off;
		!ser_wr_ready_o [*8] ##1 !ser_wr_ready_o [*5];
	endsequence

	sequence s_wake_enter;
		state_r == MDRP_ST_STANDBY && !clr_lvl;
	endsequence

	a_drv_kill_off: assert property (drv_kill |=> drv_on_o == '0) // RULE_03
		else $error("driver on during protection");
	a_standby_level: assert property (!ps_s |=> standby_o && regs_clear_o) // RULE_01
		else $error("standby not reported");
	a_standby_clears: assert property (clr_lvl |=> rif.soft_rst == '0) // RULE_02
		else $error("soft-reset bits survive clear");
	a_heat_keeps_regs: assert property (therm_s && !clr_lvl && !rif.wr_en |=> $stable(rif.soft_rst)) // RULE_04
		else $error("thermal shutdown changed registers");
	a_soft_rst_pin: assert property (!drv_kill && rif.soft_rst != '0 |=>
		((drv_on_o & $past(rif.soft_rst)) == ($past(en_s) & $past(rif.soft_rst)))) // RULE_05
		else $error("soft-reset channel ignores enable pin");
	a_wake_guard: assert property (s_wake_start |-> s_held_off) // RULE_06
		else $error("serial accepted before wake time");
	a_wake_ready: assert property (calm_cnt_r >= 5'(WAKE_CYC + 2) && !clr_lvl |-> ser_wr_ready_o) // RULE_06
		else $error("serial not ready after wake");
	a_no_write_clr: assert property (clr_lvl |-> !rif.wr_en && !ser_wr_ready_o) // RULE_07
		else $error("write accepted during standby");

	// wake sequencing
	a_wake_early: assert property (calm_cnt_r < 5'(WAKE_CYC + 2) |-> !ser_wr_ready_o) // RULE_06
		else $error("serial ready inside wake time");
	a_wake_enter: assert property (s_wake_enter |=> state_r == MDRP_ST_WAKE) // RULE_06
		else $error("wake not started after release");
	a_wake_cnt_bound: assert property (state_r == MDRP_ST_WAKE |-> wake_cnt_r <= WAKE_CNT_MAX) // RULE_06
		else $error("wake counter past its end");
	a_wake_abort: assert property (state_r == MDRP_ST_WAKE && clr_lvl |=> state_r == MDRP_ST_STANDBY) // RULE_07
		else $error("wake kept under clear level");
	a_run_hold: assert property (state_r == MDRP_ST_RUN && !clr_lvl |=> state_r == MDRP_ST_RUN) // RULE_07
		else $error("run left without clear level");

	// clear and lockout reporting
	a_standby_state: assert property (clr_lvl |=> state_r == MDRP_ST_STANDBY) // RULE_07
		else $error("state not standby under clear");
	a_normal_level: assert property (ps_s |=> !standby_o) // RULE_01
		else $error("standby reported in normal mode");
	a_clear_report: assert property (clr_lvl |=> regs_clear_o) // RULE_02
		else $error("clear level not reported");
	a_clear_drop: assert property (!clr_lvl |=> !regs_clear_o) // RULE_02
		else $error("clear reported without cause");
	a_lockout_clear: assert property (lockout_s |=> // RULE_02 RULE_03
		regs_clear_o && drv_on_o == '0 && rif.soft_rst == '0)
		else $error("lockout left registers or drivers");
	a_write_gate: assert property (rif.wr_en |-> state_r == MDRP_ST_RUN && !clr_lvl) // RULE_07
		else $error("write taken outside run");

	// thermal shutdown and normal drive
	a_heat_no_clear: assert property (therm_s && !clr_lvl |=> !regs_clear_o) // RULE_04
		else $error("thermal shutdown cleared registers");
	a_soft_kill: assert property (rif.soft_rst != '0 && drv_kill |=> drv_on_o == '0) // RULE_03
		else $error("soft-reset channel on during protection");
	a_req_follows: assert property (!drv_kill && rif.soft_rst == '0 |=> // RULE_05
		drv_on_o == $past(drv_req_i))
		else $error("driver ignores its request");
endmodule

// ==== verif/mdrp_host_model.sv ====
// host model issuing serial register writes
`timescale 1ns/100ps
module mdrp_host_model
	import mdrp_pkg::*;
(
	// control from bench
	input  wire logic              clk_i,
	input  wire logic              go_i,
	input  wire logic [ADDR_W-1:0] addr_i,
	input  wire logic [DATA_W-1:0] data_i,
	// serial write side
	input  wire logic              ready_i,
	output logic                   valid_o = 1'h0,
	output logic [ADDR_W-1:0]      addr_o = '0,
	output logic [DATA_W-1:0]      data_o = '0,
	output logic                   done_o = 1'h0
);
	always @(posedge clk_i) begin
		done_o <= 1'h0;
		if (valid_o && (ready_i || !go_i)) begin
			valid_o <= 1'h0;
			done_o  <= ready_i;
			// released lines scrambled
			addr_o  <= ~addr_o;
			data_o  <= ~data_o;
		end else if (go_i && !valid_o && !done_o) begin
			valid_o <= 1'h1;
			addr_o  <= addr_i;
			data_o  <= data_i;
		end
	end
endmodule

// ==== verif/test_motor_driver_reset_protect.sv ====
// self-checking bench for the reset and protect block
`timescale 1ns/100ps
module test_motor_driver_reset_protect;
	import mdrp_pkg::*;
	logic              clk = 0, srst = 1, ps = 0, uv = 0, ts = 0, go = 0;
	logic              vld, rdy, done, low_pwr, clr;
	logic [CH_NUM-1:0] en = '0, req = '0, drv;
	logic [ADDR_W-1:0] ha = '0, wa, ra = '0;
	logic [DATA_W-1:0] hd = '0, wd, rdat, v;
	int                error_cnt = 0, samples_checked = 0, n;
	always #4 clk = ~clk;
	mdrp_top dut (.clk_i(clk), .srst_i(srst), .power_save_input_i(ps), .undervoltage_lockout_i(uv),
		.thermal_shutdown_i(ts), .channel_enable_pin_i(en), .ser_wr_valid_i(vld), .ser_wr_addr_i(wa),
		.ser_wr_data_i(wd), .ser_wr_ready_o(rdy), .rd_addr_i(ra), .rd_data_o(rdat), .drv_req_i(req),
		.drv_on_o(drv), .standby_o(low_pwr), .regs_clear_o(clr));
	mdrp_host_model host (.clk_i(clk), .go_i(go), .addr_i(ha), .data_i(hd), .ready_i(rdy),
		.valid_o(vld), .addr_o(wa), .data_o(wd), .done_o(done));
	task automatic stop_test();
		$display("counts: %0d errors, %0d checks", error_cnt, samples_checked);
		if (error_cnt == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic step(int k);
		repeat (k) @(posedge clk);
		#1;
	endtask
	task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
		samples_checked++;
		if (g !== e) begin
			error_cnt++;
			$display("wrong value %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic rd(logic [3:0] a);
		ra <= a;
		step(2);
		v = rdat;
	endtask
	// bounded wait for ready, counted in n
	task automatic wait_rdy();
		for (n = 0; n < 60 && rdy !== 1'h1; n++) step(1);
		if (rdy !== 1'h1) begin
			error_cnt++;
			stop_test();
		end
	endtask
	task automatic wr(logic [3:0] a, logic [7:0] d);
		int i;
		ha <= a;
		hd <= d;
		go <= 1'h1;
		for (i = 0; i < 40 && done !== 1'h1; i++) step(1);
		if (done !== 1'h1) begin
			error_cnt++;
			stop_test();
		end
		go <= 1'h0;
		step(1);
	endtask
	task automatic t_wake();
		chk("standby", 8'h01, {7'h0, low_pwr});
		chk("clear", 8'h01, {7'h0, clr});
		ps <= 1'h1;
		wait_rdy();
		chk("wake gap", 8'h01, {7'h0, n >= WAKE_CYC + 2});
		chk("standby run", 8'h00, {7'h0, low_pwr});
		chk("clear run", 8'h00, {7'h0, clr});
		wr(4'h3, 8'hA5);
		rd(4'h3);
		chk("reg3", 8'hA5, v);
		$display("done wake");
	endtask
	task automatic t_soft();
		en <= 5'h1F;
		wr(SOFT_RST_ADDR, 8'h1F);
		step(4);
		chk("drv soft", 8'h1F, {3'h0, drv});
		en <= 5'h0A;
		step(4);
		chk("drv en", 8'h0A, {3'h0, drv});
		ts <= 1'h1;
		step(4);
		chk("drv heat", 8'h00, {3'h0, drv});
		chk("clear heat", 8'h00, {7'h0, clr});
		rd(4'h3);
		chk("reg3 heat", 8'hA5, v);
		ts <= 1'h0;
		wr(SOFT_RST_ADDR, 8'h00);
		req <= 5'h15;
		step(4);
		chk("drv req", 8'h15, {3'h0, drv});
		$display("done soft");
	endtask
	task automatic t_lock();
		uv <= 1'h1;
		step(4);
		chk("drv lockout", 8'h00, {3'h0, drv});
		chk("clear lockout", 8'h01, {7'h0, clr});
		chk("standby lockout", 8'h00, {7'h0, low_pwr});
		rd(4'h3);
		chk("reg3 lockout", 8'h00, v);
		ha <= 4'h3;
		hd <= 8'h3C;
		go <= 1'h1;
		step(6);
		go <= 1'h0;
		uv <= 1'h0;
		wait_rdy();
		rd(4'h3);
		chk("reg3 after", 8'h00, v);
		$display("done lock");
	endtask
	task automatic t_save();
		wr(4'h3, 8'h5A);
		rd(4'h3);
		chk("reg3 run", 8'h5A, v);
		ps <= 1'h0;
		step(4);
		chk("standby", 8'h01, {7'h0, low_pwr});
		chk("clear save", 8'h01, {7'h0, clr});
		chk("drv save", 8'h00, {3'h0, drv});
		rd(4'h3);
		chk("reg3 save", 8'h00, v);
		$display("done save");
	endtask
	initial begin
		step(2);
		srst <= 1'h0;
		step(1);
		t_wake();
		t_soft();
		t_lock();
		t_save();
		stop_test();
	end
endmodule
